/* File: logic/rwu_map.svh */
// Purpose: offsets, field positions, reset values and counts of the reset and watchdog unit
// Assumes: 25 MHz system clock
// Notes:   definitions only
`ifndef RWU_MAP_SVH
`define RWU_MAP_SVH

`define RWU_ADDR_STATUS   8'h00
`define RWU_ADDR_OPT1     8'h04
`define RWU_ADDR_OPT2     8'h08
`define RWU_ADDR_IOCTL    8'h0C

`define RWU_OPT1_RESET    8'hC0
`define RWU_OPT2_RESET    8'h00
`define RWU_OPT1_TSEL_HI  7
`define RWU_OPT1_TSEL_LO  6
`define RWU_OPT1_PINEN    0
`define RWU_OPT2_CLKSEL   7
`define RWU_OPT2_WINEN    6
`define RWU_IOCTL_PERIPH  16

`define RWU_CAUSE_POR     8'h80
`define RWU_CAUSE_PIN     8'h40
`define RWU_CAUSE_WDOG    8'h20
`define RWU_CAUSE_BADOP   8'h10
`define RWU_CAUSE_BADADR  8'h08
`define RWU_CAUSE_LOWV    8'h02

`define RWU_SVC_FIRST     16'h0055
`define RWU_SVC_SECOND    16'h00AA
`define RWU_VEC_HI        16'hFFFE
`define RWU_VEC_LO        16'hFFFF
`define RWU_SP_INIT       16'h00FF
`define RWU_RST_HOLD      4'h8

`define RWU_CLK_NS        40
`define RWU_LPO_NS        1000000

`define RWU_LIM_LPO_01    19'h00020
`define RWU_LIM_LPO_10    19'h00100
`define RWU_LIM_LPO_11    19'h00400
`define RWU_LIM_BUS_01    19'h02000
`define RWU_LIM_BUS_10    19'h10000
`define RWU_LIM_BUS_11    19'h40000
`define RWU_WIN_BUS_01    19'h01800
`define RWU_WIN_BUS_10    19'h0C000
`define RWU_WIN_BUS_11    19'h30000

`define RWU_RESP_OKAY     2'h0
`define RWU_RESP_SLVERR   2'h2

`endif

/* File: logic/rwu_pkg.sv */
// Purpose: types of the reset and watchdog unit
// Assumes: constants live in rwu_map.svh
// Notes:   none
package rwu_pkg;
    typedef enum logic {
        RWU_RUN  = 1'b0,
        RWU_HOLD = 1'b1
    } rwu_rst_state_t;

    typedef logic [18:0] rwu_wd_count_t;
    typedef logic [1:0]  rwu_tsel_t;
endpackage : rwu_pkg

/* File: logic/rwu_reset_watchdog.sv */
// Purpose: reset sequencing, reset cause capture and watchdog with AXI4-Lite registers
// Assumes: memRdData answers memAddr in the same cycle; inputs synchronous to clk
// Notes:   the bus handshake survives internal resets, only sys_rst clears it
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`include "rwu_map.svh"

// Summary of operation
// RULE_01: reset loads program counter from top vector
// RULE_02: reset forces stack pointer to fixed value
// RULE_03: reset sets the interrupt mask bit
// RULE_04: reset disables peripherals, pins input, pulls off
// RULE_05: accept listed reset sources, record cause bits
// RULE_06: unimplemented address access forces illegal-address reset
// RULE_07: watchdog enabled after reset until select zero
// RULE_08: first then second value restarts timeout
// RULE_09: status writes never change stored contents
// RULE_10: any other status write resets immediately
// RULE_11: timeout without service resets the device
// RULE_12: clock select bit picks 1 kHz or bus
// RULE_13: 1 kHz timeouts 2^5/2^8/2^10, longest default
// RULE_14: bus timeouts 2^13/2^16/2^18 cycles
// RULE_15: windowed bus mode: early service resets device
// RULE_16: window opens at 6144/49152/196608 cycles
// RULE_17: no windowing with the 1 kHz clock
// RULE_18: option registers are write-once per reset
// RULE_19: bus-clocked counter holds in debug, stop
// RULE_20: 1 kHz counter clears in debug, stop
// RULE_21: software should write both option registers early
// RULE_22: status shows cause of most recent reset
// RULE_23: lone second value does not restart timeout
module rwu_reset_watchdog
    import rwu_pkg::*;
#(
    parameter int          LPO_DIV     = `RWU_LPO_NS / `RWU_CLK_NS,
    parameter logic [15:0] UNIMPL_BASE = 16'h1000,
    parameter logic [15:0] UNIMPL_LAST = 16'h7FFF
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        extResetReq,
    input  wire logic        lowVoltageDetect,
    input  wire logic        illegalOpcodeDetect,
    input  wire logic        debugResetReq,
    input  wire logic        debugMode,
    input  wire logic        stopMode,
    input  wire logic        cpuAccess,
    input  wire logic [15:0] cpuAddr,
    input  wire logic        intMaskClr,
    input  wire logic [7:0]  memRdData,
    output logic [15:0]      memAddr,
    output logic             sysResetOut,
    output logic [15:0]      progCounter,
    output logic [15:0]      stackPtr,
    output logic             intMask,
    output logic             periphEnable,
    output logic [7:0]       pinOutEn,
    output logic [7:0]       pinPullEn
);

    rwu_rst_state_t rstState_reg;
    logic [3:0]     holdCnt_reg;
    logic [7:0]     cause_reg;
    logic [7:0]     opt1_reg;
    logic [7:0]     opt2_reg;
    logic           opt1Done_reg;
    logic           opt2Done_reg;
    logic [16:0]    ioCtrl_reg;
    rwu_wd_count_t  wdCount_reg;
    logic           svcArmed_reg;
    logic [31:0]    lpoCnt_reg;
    logic           lpoTick_reg;
    logic           awHeld_reg;
    logic           wHeld_reg;
    logic [7:0]     awAddr_reg;
    logic [31:0]    wData_reg;
    logic [3:0]     wStrb_reg;

    logic           inReset;
    logic           wrCommit;
    logic           statusWr;
    logic [15:0]    svcVal;
    rwu_tsel_t      tsel;
    logic           wdOn;
    logic           busClk;
    logic           halt;
    logic           step;
    logic           timeout;
    logic           early;
    logic           badSvc;
    logic           earlySvc;
    logic           restart;
    logic [7:0]     evBits;
    logic           evReq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    function automatic logic regMapped(input logic [7:0] a);
        return a == `RWU_ADDR_STATUS || a == `RWU_ADDR_OPT1 || a == `RWU_ADDR_OPT2 || a == `RWU_ADDR_IOCTL;
    endfunction : regMapped

    function automatic rwu_wd_count_t wdLimit(input logic bus, input rwu_tsel_t sel);
        case ({bus, sel})
            3'b001:  return `RWU_LIM_LPO_01;
            3'b010:  return `RWU_LIM_LPO_10;
            3'b011:  return `RWU_LIM_LPO_11;
            3'b101:  return `RWU_LIM_BUS_01;
            3'b110:  return `RWU_LIM_BUS_10;
            default: return `RWU_LIM_BUS_11;
        endcase
    endfunction : wdLimit

    function automatic rwu_wd_count_t wdWindow(input rwu_tsel_t sel);
        case (sel)
            2'b01:   return `RWU_WIN_BUS_01;
            2'b10:   return `RWU_WIN_BUS_10;
            default: return `RWU_WIN_BUS_11;
        endcase
    endfunction : wdWindow

    assign inReset  = sys_rst || rstState_reg == RWU_HOLD;
    // writes wait out an internal reset so their effect is never lost
    assign wrCommit = awHeld_reg && wHeld_reg && !s_axi_bvalid && !inReset;
    assign statusWr = wrCommit && awAddr_reg == `RWU_ADDR_STATUS;
    assign svcVal   = wData_reg[15:0];

    always_comb begin
        tsel     = opt1_reg[`RWU_OPT1_TSEL_HI:`RWU_OPT1_TSEL_LO];
        wdOn     = tsel != 2'h0; // RULE_07
        busClk   = opt2_reg[`RWU_OPT2_CLKSEL]; // RULE_12
        halt     = debugMode || stopMode;
        step     = busClk ? !halt : (lpoTick_reg && !halt);
        // a late select change can leave the count past the new limit, so compare with >=
        timeout  = wdOn && step && wdCount_reg >= wdLimit(busClk, tsel) - 19'h00001; // RULE_11 RULE_13 RULE_14
        // window only exists on the bus clock
        early    = busClk && opt2_reg[`RWU_OPT2_WINEN] && wdCount_reg < wdWindow(tsel); // RULE_16 RULE_17
        badSvc   = statusWr && svcVal != `RWU_SVC_FIRST && svcVal != `RWU_SVC_SECOND; // RULE_10
        earlySvc = statusWr && wdOn && early; // RULE_15
        restart  = statusWr && svcVal == `RWU_SVC_SECOND && svcArmed_reg; // RULE_08 RULE_23
    end

    always_comb begin
        evBits = 8'h00;
        if (extResetReq && opt1_reg[`RWU_OPT1_PINEN]) begin
            evBits = evBits | `RWU_CAUSE_PIN;
        end
        if (lowVoltageDetect) begin
            evBits = evBits | `RWU_CAUSE_LOWV;
        end
        if (illegalOpcodeDetect) begin
            evBits = evBits | `RWU_CAUSE_BADOP;
        end
        if (cpuAccess && cpuAddr >= UNIMPL_BASE && cpuAddr <= UNIMPL_LAST) begin
            evBits = evBits | `RWU_CAUSE_BADADR; // RULE_06
        end
        if (timeout || badSvc || earlySvc) begin
            evBits = evBits | `RWU_CAUSE_WDOG;
        end
        // debug-forced reset leaves every cause bit clear
        evReq = (evBits != 8'h00) || debugResetReq; // RULE_05
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rstState_reg <= RWU_HOLD;
            holdCnt_reg  <= 4'h0;
            cause_reg    <= `RWU_CAUSE_POR; // RULE_05
            sysResetOut  <= 1'b1;
        end else if (rstState_reg == RWU_RUN) begin
            if (evReq) begin
                rstState_reg <= RWU_HOLD;
                holdCnt_reg  <= 4'h0;
                cause_reg    <= evBits; // RULE_22
                sysResetOut  <= 1'b1;
            end
        end else if (holdCnt_reg == `RWU_RST_HOLD - 4'h1) begin
            rstState_reg <= RWU_RUN;
            sysResetOut  <= 1'b0;
        end else begin
            holdCnt_reg <= holdCnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (inReset) begin
            stackPtr <= `RWU_SP_INIT; // RULE_02
            intMask  <= 1'b1; // RULE_03
            case (holdCnt_reg)
                4'h1: begin
                    progCounter[15:8] <= memRdData; // RULE_01
                    memAddr           <= `RWU_VEC_LO;
                end
                4'h2: begin
                    progCounter[7:0] <= memRdData; // RULE_01
                end
                default: begin
                    memAddr <= `RWU_VEC_HI;
                end
            endcase
        end else if (intMaskClr) begin
            intMask <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (inReset) begin
            ioCtrl_reg <= 17'h00000; // RULE_04
        end else if (wrCommit && awAddr_reg == `RWU_ADDR_IOCTL) begin
            if (wStrb_reg[0]) begin
                ioCtrl_reg[7:0] <= wData_reg[7:0];
            end
            if (wStrb_reg[1]) begin
                ioCtrl_reg[15:8] <= wData_reg[15:8];
            end
            if (wStrb_reg[2]) begin
                ioCtrl_reg[16] <= wData_reg[16];
            end
        end
    end

    assign pinOutEn     = ioCtrl_reg[7:0];
    assign pinPullEn    = ioCtrl_reg[15:8];
    assign periphEnable = ioCtrl_reg[`RWU_IOCTL_PERIPH];

    // any first write locks the register, even one with no byte lane set
    always_ff @(posedge clk) begin
        if (inReset) begin
            opt1_reg     <= `RWU_OPT1_RESET; // RULE_13
            opt2_reg     <= `RWU_OPT2_RESET;
            opt1Done_reg <= 1'b0;
            opt2Done_reg <= 1'b0;
        end else if (wrCommit) begin
            if (awAddr_reg == `RWU_ADDR_OPT1 && !opt1Done_reg) begin
                opt1Done_reg <= 1'b1; // RULE_18
                if (wStrb_reg[0]) begin
                    opt1_reg <= wData_reg[7:0];
                end
            end
            if (awAddr_reg == `RWU_ADDR_OPT2 && !opt2Done_reg) begin
                opt2Done_reg <= 1'b1; // RULE_18
                if (wStrb_reg[0]) begin
                    opt2_reg <= wData_reg[7:0];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (inReset || lpoCnt_reg == 32'(LPO_DIV - 1)) begin
            lpoCnt_reg  <= 32'h00000000;
            lpoTick_reg <= !inReset;
        end else begin
            lpoCnt_reg  <= lpoCnt_reg + 32'h00000001;
            lpoTick_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (inReset || restart) begin
            wdCount_reg <= 19'h00000; // RULE_08
        end else if (!busClk && halt) begin
            wdCount_reg <= 19'h00000; // RULE_20
        end else if (wdOn && step) begin
            wdCount_reg <= wdCount_reg + 19'h00001; // RULE_19
        end
    end

    always_ff @(posedge clk) begin
        if (inReset) begin
            svcArmed_reg <= 1'b0;
        end else if (statusWr) begin
            svcArmed_reg <= svcVal == `RWU_SVC_FIRST; // RULE_23
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            awHeld_reg    <= 1'b0;
            wHeld_reg     <= 1'b0;
            awAddr_reg    <= 8'h00;
            wData_reg     <= 32'h00000000;
            wStrb_reg     <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RWU_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_reg    <= s_axi_awaddr;
                awHeld_reg    <= 1'b1;
                s_axi_awready <= 1'b0;
            end else if (!awHeld_reg && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_reg    <= s_axi_wdata;
                wStrb_reg    <= s_axi_wstrb;
                wHeld_reg    <= 1'b1;
                s_axi_wready <= 1'b0;
            end else if (!wHeld_reg && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (wrCommit) begin
                awHeld_reg   <= 1'b0;
                wHeld_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= regMapped(awAddr_reg) ? `RWU_RESP_OKAY : `RWU_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RWU_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= regMapped(s_axi_araddr) ? `RWU_RESP_OKAY : `RWU_RESP_SLVERR;
            if (s_axi_araddr == `RWU_ADDR_STATUS) begin
                s_axi_rdata <= {24'h000000, cause_reg}; // RULE_22
            end else if (s_axi_araddr == `RWU_ADDR_OPT1) begin
                s_axi_rdata <= {24'h000000, opt1_reg};
            end else if (s_axi_araddr == `RWU_ADDR_OPT2) begin
                s_axi_rdata <= {24'h000000, opt2_reg};
            end else if (s_axi_araddr == `RWU_ADDR_IOCTL) begin
                s_axi_rdata <= {15'h0000, ioCtrl_reg};
            end else begin
                s_axi_rdata <= 32'h00000000;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    vec_fetch_a: assert property (rstState_reg == RWU_HOLD && holdCnt_reg == 4'h1 |-> memAddr == `RWU_VEC_HI) // RULE_01
        else $error("vector high byte not addressed");
    sp_init_a: assert property ($fell(sysResetOut) |-> stackPtr == `RWU_SP_INIT) // RULE_02
        else $error("stack pointer not initialised");
    int_mask_a: assert property ($fell(sysResetOut) |-> intMask) // RULE_03
        else $error("interrupt mask clear after reset");
    pins_off_a: assert property (sysResetOut && $past(sysResetOut) |-> pinOutEn == 8'h00 && pinPullEn == 8'h00 && !periphEnable) // RULE_04
        else $error("pins or peripherals active in reset");
    status_ro_a: assert property (statusWr && !evReq |=> $stable(cause_reg)) // RULE_09
        else $error("status write altered contents");
    bad_svc_a: assert property (badSvc |=> sysResetOut && cause_reg[5]) // RULE_10
        else $error("bad service value did not reset");
    timeout_rst_a: assert property (timeout |=> sysResetOut ##1 sysResetOut) // RULE_11
        else $error("timeout did not reset");
    early_svc_a: assert property (earlySvc |=> sysResetOut && (cause_reg & `RWU_CAUSE_WDOG) != 8'h00) // RULE_15
        else $error("early service did not reset");
    opt_lock_a: assert property (opt1Done_reg && !inReset |=> $stable(opt1_reg)) // RULE_18
        else $error("option register changed after lock");
    bus_hold_a: assert property (busClk && halt && !inReset && !restart |=> $stable(wdCount_reg)) // RULE_19
        else $error("bus counter moved while halted");
    lpo_clear_a: assert property (!busClk && halt && !inReset |=> wdCount_reg == 19'h00000) // RULE_20
        else $error("slow counter not cleared in halt");

    svc_pair_c: cover property (statusWr && svcVal == `RWU_SVC_FIRST ##[1:20] restart);
    timeout_c: cover property (timeout);
    win_svc_c: cover property (busClk && opt2_reg[`RWU_OPT2_WINEN] && restart);

endmodule : rwu_reset_watchdog

/* File: test/rwu_reset_watchdog_tb.sv */
// Purpose: self-checking bench of the reset and watchdog unit
// Assumes: LPO_DIV shortened to 8 clocks per slow tick
// Notes:   timing windows allow for bus latency and slow-tick phase
`include "rwu_map.svh"
module rwu_reset_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LPO = 8;
    logic        clk = 1'h0, sys_rst = 1'h1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, memRdData, vecHi, vecLo;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rDat, bad;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bRsp, rRsp;
    logic        extResetReq = 1'h0, lowVoltageDetect = 1'h0, illegalOpcodeDetect = 1'h0;
    logic        debugResetReq = 1'h0, debugMode = 1'h0, stopMode = 1'h0, cpuAccess = 1'h0;
    logic        intMaskClr = 1'h0, sysResetOut, intMask, periphEnable;
    logic [15:0] cpuAddr = 16'h0, memAddr, progCounter, stackPtr;
    logic [7:0]  pinOutEn, pinPullEn;
    logic [7:0]  cause [6];
    int          errors = 0, checks_done = 0, n = 0;
    int          seed = 32'h1CB5FCBB;

    always #20 clk = ~clk;
    // other addresses return a changing pattern so a wrong fetch address shows
    assign memRdData = (memAddr == `RWU_VEC_HI) ? vecHi : (memAddr == `RWU_VEC_LO) ? vecLo : ~memAddr[7:0];

    rwu_reset_watchdog #(.LPO_DIV(LPO)) u_dut (
        .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .extResetReq, .lowVoltageDetect,
        .illegalOpcodeDetect, .debugResetReq, .debugMode, .stopMode, .cpuAccess, .cpuAddr,
        .intMaskClr, .memRdData, .memAddr, .sysResetOut, .progCounter, .stackPtr, .intMask,
        .periphEnable, .pinOutEn, .pinPullEn
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // overflow count in watchdog ticks for a clock choice and timeout select
    function automatic int expLimit(input logic bus, input logic [1:0] sel);
        int sh;
        sh = bus ? ((sel == 2'h1) ? 13 : (sel == 2'h2) ? 16 : 18) : ((sel == 2'h1) ? 5 : (sel == 2'h2) ? 8 : 10);
        return 1 << sh;
    endfunction : expLimit

    task automatic report_and_stop;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic hang;
        check(32'h0, 32'h1);
        report_and_stop();
    endtask : hang

    // address and data offered together, each dropped once taken
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        for (int i = 0; i < 4000; i++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && s_axi_bready) begin
                bRsp = s_axi_bresp;
                s_axi_bready <= 1'h0;
                return;
            end
        end
        hang();
    endtask : axiWrite

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        for (int i = 0; i < 4000; i++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && s_axi_rready) begin
                rDat = s_axi_rdata;
                rRsp = s_axi_rresp;
                s_axi_rready <= 1'h0;
                return;
            end
        end
        hang();
    endtask : rd

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        check(rDat, e);
    endtask : rdChk

    task automatic cfg(input logic [31:0] o2, input logic [31:0] o1);
        axiWrite(`RWU_ADDR_OPT2, o2);
        axiWrite(`RWU_ADDR_OPT1, o1);
    endtask : cfg

    task automatic svc;
        axiWrite(`RWU_ADDR_STATUS, {16'h0000, `RWU_SVC_FIRST});
        axiWrite(`RWU_ADDR_STATUS, {16'h0000, `RWU_SVC_SECOND});
    endtask : svc

    // n ends as the edge count until reset rises, or lim if it never does
    task automatic waitRise(input int lim);
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            if (sysResetOut === 1'h1) return;
        end
    endtask : waitRise

    task automatic recover;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            if (sysResetOut === 1'h0) return;
        end
        hang();
    endtask : recover

    task automatic doReset;
        sys_rst <= 1'h1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'h0;
        recover();
    endtask : doReset

    task automatic near(input int lo, input int hi);
        check(32'(n >= lo && n <= hi), 32'h1);
    endtask : near

    task automatic checkInit;
        check(progCounter, {vecHi, vecLo});
        check(stackPtr, `RWU_SP_INIT);
        check(intMask, 1'h1);
        check({periphEnable, pinOutEn, pinPullEn}, 17'h0);
    endtask : checkInit

    task automatic fire(input int k);
        @(posedge clk);
        case (k)
            0: lowVoltageDetect <= 1'h1;
            1: illegalOpcodeDetect <= 1'h1;
            3: extResetReq <= 1'h1;
            4: debugResetReq <= 1'h1;
            default: begin
                cpuAccess   <= 1'h1;
                cpuAddr     <= (k == 2) ? 16'h0FFF : 16'h1000 + 16'($random(seed) & 32'h6FFF);
                extResetReq <= (k == 2);
            end
        endcase
        @(posedge clk);
        {lowVoltageDetect, illegalOpcodeDetect, extResetReq, debugResetReq, cpuAccess} <= 5'h0;
    endtask : fire

    initial begin
        vecHi = 8'($random(seed));
        vecLo = 8'($random(seed));
        cause = '{`RWU_CAUSE_LOWV, `RWU_CAUSE_BADOP, `RWU_CAUSE_BADOP, `RWU_CAUSE_PIN, 8'h00, `RWU_CAUSE_BADADR};
        doReset();
        checkInit();
        rdChk(`RWU_ADDR_STATUS, `RWU_CAUSE_POR);
        rdChk(`RWU_ADDR_OPT1, `RWU_OPT1_RESET);
        rdChk(8'h10, 32'h0);
        check(rRsp, `RWU_RESP_SLVERR);
        axiWrite(`RWU_ADDR_IOCTL, 32'h1FFFF);
        @(posedge clk) intMaskClr <= 1'h1;
        @(posedge clk) intMaskClr <= 1'h0;
        @(posedge clk);
        check({intMask, periphEnable, pinOutEn, pinPullEn}, 18'h1FFFF);
        waitRise(9000);
        near(expLimit(1'h0, 2'h3) * LPO - 60, expLimit(1'h0, 2'h3) * LPO + 8);
        recover();
        checkInit();
        rdChk(`RWU_ADDR_STATUS, `RWU_CAUSE_WDOG);
        // pin request without its enable and a legal address must both be ignored
        for (int k = 0; k < 6; k++) begin
            if (k == 3) axiWrite(`RWU_ADDR_OPT1, 32'hC1);
            fire(k);
            waitRise(20);
            check(32'(n < 20), 32'(k != 2));
            if (k != 2) recover();
            rdChk(`RWU_ADDR_STATUS, cause[k]);
        end
        axiWrite(`RWU_ADDR_STATUS, 32'h55);
        rdChk(`RWU_ADDR_STATUS, `RWU_CAUSE_BADADR);
        bad = $random(seed);
        if (bad[15:0] == 16'h0055 || bad[15:0] == 16'h00AA) bad[8] = ~bad[8];
        axiWrite(`RWU_ADDR_STATUS, bad);
        rdChk(`RWU_ADDR_STATUS, `RWU_CAUSE_WDOG);
        axiWrite(`RWU_ADDR_OPT1, 32'h00);
        check(bRsp, `RWU_RESP_OKAY);
        axiWrite(`RWU_ADDR_OPT1, 32'h40);
        rdChk(`RWU_ADDR_OPT1, 32'h0);
        waitRise(9000);
        check(n, 9000);
        doReset();
        rdChk(`RWU_ADDR_STATUS, `RWU_CAUSE_POR);
        cfg(32'h40, 32'h40);
        svc();
        repeat (150) @(posedge clk);
        debugMode <= 1'h1;
        repeat (300) @(posedge clk);
        debugMode <= 1'h0;
        waitRise(400);
        near(expLimit(1'h0, 2'h1) * LPO - 16, expLimit(1'h0, 2'h1) * LPO + 8);
        recover();
        cfg(32'h80, 32'h40);
        svc();
        waitRise(6000);
        check(n, 6000);
        svc();
        waitRise(9000);
        near(expLimit(1'h1, 2'h1) - 12, expLimit(1'h1, 2'h1) + 4);
        recover();
        // a lone second value must not restart, and stop must freeze the count
        cfg(32'h80, 32'h40);
        svc();
        waitRise(2000);
        axiWrite(`RWU_ADDR_STATUS, 32'hAA);
        stopMode <= 1'h1;
        repeat (1000) @(posedge clk);
        stopMode <= 1'h0;
        waitRise(9000);
        near(6172, 6196);
        recover();
        cfg(32'hC0, 32'h40);
        svc();
        rdChk(`RWU_ADDR_OPT1, `RWU_OPT1_RESET);
        cfg(32'hC0, 32'h40);
        waitRise(6200);
        svc();
        waitRise(300);
        check(n, 300);
        rdChk(`RWU_ADDR_OPT1, 32'h40);
        report_and_stop();
    end
endmodule : rwu_reset_watchdog_tb
